// [logic/icl_ctrl.sv]
// interrupt control logic: flags, enables, vector request and wake
// Functional notes
// - flags set regardless of any enable
// - global enable bit 7 gates vector requests, not sleep wake
// - vector after a fixed q4 count when enabled flag pending
// - reset clears the global enable
// - acknowledge clears enable, pushes, loads 0004h
// - return pops and sets global enable unless irq_ack or a clearing write coincides, or a clear raced irq_ack
// - external event latency three or four cycles
// - peripheral flags, enables, group enable placement
// - edge select bit 6 picks pin polarity
// - pin edge sets flag bit 1
// - pin interrupt wakes sleep if enabled
// - timer overflow sets flag bit 2
// - port change sets flag bit 0
// - pin flag may set in q4 or q1
// - only return address saved by hardware
// - up to twelve interrupt sources
// - enabled pending wakes sleep without global
module icl_ctrl
   import icl_pkg::*;
(
   // clock, enable, reset
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // instruction cycle quarter phases (one-hot)
   input  wire logic        q1,
   input  wire logic        q4,
   // register port
   input  wire logic [2:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // event sources
   input  wire logic        ext_irq_pin,
   input  wire logic        timer_zero_overflow,
   input  wire logic [3:0]  upper_io_port,
   input  wire logic [PERIPH_A_W-1:0] periph_set_a,
   input  wire logic [PERIPH_B_W-1:0] periph_set_b,
   // core sequencer
   input  wire logic        irq_ack,
   input  wire logic        return_from_irq_instr,
   input  wire logic        sleep_instr,
   input  wire logic [12:0] return_pc,
   output logic             irq_request,
   output logic             stack_push,
   output logic      [12:0] stack_push_data,
   output logic             stack_pop,
   output logic             pc_load,
   output logic      [12:0] pc_load_value,
   output logic             wake,
   output logic             asleep
);
   logic [7:0]            main_irq_control_reg;
   logic [7:0]            option_reg;
   logic [PERIPH_A_W-1:0] periph_flag_reg_a;
   logic [PERIPH_B_W-1:0] periph_flag_reg_b;
   logic [PERIPH_A_W-1:0] periph_enable_reg_a;
   logic [PERIPH_B_W-1:0] periph_enable_reg_b;
   logic [3:0]            port_last;
   logic                  ext_pending;
   logic [1:0]            lat_cnt;
   icl_state_type         state;
   icl_state_type         next_state;
   logic                  ext_edge;
   logic                  clear_raced;

   icl_edge_det u_edge (
      .clk        (clk),
      .rstn       (rstn),
      .ce         (ce),
      .pin        (ext_irq_pin),
      .rising     (option_reg[EDGE_SEL_BIT]),
      .edge_pulse (ext_edge)
   );

   // decode
   wire wr_main  = reg_wr && reg_addr == ADDR_MAIN;
   wire wr_pfa   = reg_wr && reg_addr == ADDR_PFLAG_A;
   wire wr_pfb   = reg_wr && reg_addr == ADDR_PFLAG_B;
   wire wr_pea   = reg_wr && reg_addr == ADDR_PEN_A;
   wire wr_peb   = reg_wr && reg_addr == ADDR_PEN_B;
   wire wr_opt   = reg_wr && reg_addr == ADDR_OPTION;

   // the pin flag is only allowed to latch in the q4/q1 window
   wire ext_window = q4 | q1;
   wire ext_set    = ext_pending & ext_window;
   wire port_set   = |(upper_io_port ^ port_last);
   wire tmr_set    = timer_zero_overflow;

   wire global_irq_enable = main_irq_control_reg[GLOBAL_EN_BIT];
   wire core_any =
      (main_irq_control_reg[TMR_FL_BIT]  & main_irq_control_reg[TMR_EN_BIT])
    | (main_irq_control_reg[EXT_FL_BIT]  & main_irq_control_reg[EXT_EN_BIT])
    | (main_irq_control_reg[PORT_FL_BIT] & main_irq_control_reg[PORT_EN_BIT]);
   wire periph_any = main_irq_control_reg[GROUP_EN_BIT] &
      (|(periph_flag_reg_a & periph_enable_reg_a) |
       |(periph_flag_reg_b & periph_enable_reg_b));
   wire pending_any = core_any | periph_any;
   wire next_request =
      global_irq_enable & pending_any;

   // software write of the main register; a racing acknowledge wins the
   // enable clear, and the return only sets it when no write clears it
   wire [7:0] main_sw   = wr_main ? reg_wdata : main_irq_control_reg;
   wire       sw_clears = wr_main && !reg_wdata[GLOBAL_EN_BIT];
   // a clear that lands with an acknowledge is remembered, so the return
   // that ends the service cannot quietly turn interrupts back on
   wire       ret_sets  = return_from_irq_instr && !sw_clears &&
                          !clear_raced;
   wire       next_clear_raced = (irq_ack && sw_clears) |
                                 (clear_raced && !return_from_irq_instr);
   wire       next_global_en = irq_ack  ? 1'b0 :
                               ret_sets ? 1'b1 :
                               main_sw[GLOBAL_EN_BIT];
   wire [7:0] next_main = {next_global_en, main_sw[6:3],
                           main_sw[TMR_FL_BIT]  | tmr_set,
                           main_sw[EXT_FL_BIT]  | ext_set,
                           main_sw[PORT_FL_BIT] | port_set};

   wire [PERIPH_A_W-1:0] next_pfa =
      (wr_pfa ? reg_wdata[PERIPH_A_W-1:0] : periph_flag_reg_a) | periph_set_a;
   wire [PERIPH_B_W-1:0] next_pfb =
      (wr_pfb ? reg_wdata[PERIPH_B_W-1:0] : periph_flag_reg_b) | periph_set_b;

   // read mux
   wire [7:0] status_view = {5'h00, asleep, state == ICL_WAIT, irq_request};
   wire [7:0] next_rdata =
      reg_addr == ADDR_MAIN    ? main_irq_control_reg :
      reg_addr == ADDR_PFLAG_A ? periph_flag_reg_a :
      reg_addr == ADDR_PFLAG_B ? {7'h00, periph_flag_reg_b} :
      reg_addr == ADDR_PEN_A   ? periph_enable_reg_a :
      reg_addr == ADDR_PEN_B   ? {7'h00, periph_enable_reg_b} :
      reg_addr == ADDR_OPTION  ? option_reg :
      reg_addr == ADDR_STATUS  ? status_view : 8'h00;

   // request waits a fixed count so pin events see three or four cycles
   always_comb begin
      next_state = state;
      unique case (state)
         ICL_RUN: begin
            if (sleep_instr && !pending_any)
               next_state = ICL_SLEEP;
            else if (next_request)
               next_state = ICL_WAIT;
         end
         ICL_WAIT: begin
            if (!next_request)
               next_state = ICL_RUN;
            else if (irq_ack)
               next_state = ICL_RUN;
         end
         ICL_SLEEP: begin
            if (pending_any)
               next_state = ICL_RUN;
         end
         default: next_state = ICL_RUN;
      endcase
   end

   // main register: software writes, event sets and core effects merge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         main_irq_control_reg <= MAIN_RESET;
      end else if (ce) begin
         main_irq_control_reg <= next_main;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clear_raced <= 1'b0;
      end else if (ce) begin
         clear_raced <= next_clear_raced;
      end
   end

   // only the edge select bit of the option register is used here
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         option_reg <= OPTION_RESET;
      end else if (ce && wr_opt) begin
         option_reg <= reg_wdata;
      end
   end

   // peripheral flags: a set pulse wins over a software clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         periph_flag_reg_a <= PREG_RESET[PERIPH_A_W-1:0];
         periph_flag_reg_b <= PREG_RESET[PERIPH_B_W-1:0];
      end else if (ce) begin
         periph_flag_reg_a <= next_pfa;
         periph_flag_reg_b <= next_pfb;
      end
   end

   // peripheral enables change only by software
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         periph_enable_reg_a <= PREG_RESET[PERIPH_A_W-1:0];
         periph_enable_reg_b <= PREG_RESET[PERIPH_B_W-1:0];
      end else if (ce) begin
         if (wr_pea)
            periph_enable_reg_a <= reg_wdata[PERIPH_A_W-1:0];
         if (wr_peb)
            periph_enable_reg_b <= reg_wdata[PERIPH_B_W-1:0];
      end
   end

   // pin edge held until its latch window comes round
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_pending <= 1'b0;
      end else if (ce) begin
         ext_pending <= (ext_pending & ~ext_window) | ext_edge;
      end
   end

   // port pins compared against the previous sample each cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         port_last <= 4'h0;
      end else if (ce) begin
         port_last <= upper_io_port;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state   <= ICL_RUN;
         lat_cnt <= 2'h0;
      end else if (ce) begin
         state   <= next_state;
         lat_cnt <= (state == ICL_WAIT && q4 && lat_cnt != SYNC_CYCLES) ?
                    lat_cnt + 2'h1 : (state == ICL_WAIT ? lat_cnt : 2'h0);
      end
   end

   // outputs, all registered; only the return address is pushed
   // read data stand for one cycle and are zero otherwise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_request <= 1'b0;
      end else if (ce) begin
         irq_request <= next_request && state == ICL_WAIT &&
                        lat_cnt == SYNC_CYCLES;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stack_push      <= 1'b0;
         stack_push_data <= 13'h0000;
      end else if (ce) begin
         stack_push      <= irq_ack;
         stack_push_data <= return_pc;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stack_pop <= 1'b0;
      end else if (ce) begin
         stack_pop <= return_from_irq_instr;
      end
   end

   // the vector is a constant, loaded only in the cycle after acknowledge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc_load       <= 1'b0;
         pc_load_value <= 13'h0000;
      end else if (ce) begin
         pc_load       <= irq_ack;
         pc_load_value <= IRQ_VECTOR;
      end
   end

   // wake is one cycle wide, in the cycle that asleep drops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wake   <= 1'b0;
         asleep <= 1'b0;
      end else if (ce) begin
         wake   <= state == ICL_SLEEP && pending_any;
         asleep <= next_state == ICL_SLEEP;
      end
   end
endmodule // icl_ctrl

// [pkg/icl_pkg.sv]
// package: constants for the interrupt control logic
package icl_pkg;
   // main control register fields, then the option register edge select bit
   localparam int GLOBAL_EN_BIT = 7;
   localparam int GROUP_EN_BIT  = 6;
   localparam int TMR_EN_BIT  = 5;
   localparam int EXT_EN_BIT  = 4;
   localparam int PORT_EN_BIT = 3;
   localparam int TMR_FL_BIT  = 2;
   localparam int EXT_FL_BIT  = 1;
   localparam int PORT_FL_BIT = 0;
   localparam int EDGE_SEL_BIT = 6;
   // register offsets on the plain port
   localparam logic [2:0] ADDR_MAIN    = 3'h0;
   localparam logic [2:0] ADDR_PFLAG_A = 3'h1;
   localparam logic [2:0] ADDR_PFLAG_B = 3'h2;
   localparam logic [2:0] ADDR_PEN_A   = 3'h3;
   localparam logic [2:0] ADDR_PEN_B   = 3'h4;
   localparam logic [2:0] ADDR_OPTION  = 3'h5;
   localparam logic [2:0] ADDR_STATUS  = 3'h6;
   // reset values
   localparam logic [7:0] MAIN_RESET   = 8'h00;
   localparam logic [7:0] OPTION_RESET = 8'hff;
   localparam logic [7:0] PREG_RESET   = 8'h00;
   // widths and vector
   localparam int PERIPH_A_W = 8;
   localparam int PERIPH_B_W = 1;
   localparam int SRC_COUNT  = 12;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   // pipeline depth from event to vector request in instruction cycles
   localparam logic [1:0] SYNC_CYCLES = 2'h2;
   typedef enum logic [1:0] {
      ICL_RUN   = 2'b00,
      ICL_WAIT  = 2'b01,
      ICL_SLEEP = 2'b10
   } icl_state_type;
endpackage

// [logic/icl_edge_det.sv]
// edge detector with polarity select for the external request pin
module icl_edge_det (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic ce,
   // pin and polarity
   input  wire logic pin,
   input  wire logic rising,
   // detected edge
   output logic      edge_pulse
);
   logic last;
   logic primed;
   wire  rise_seen = pin & ~last;
   wire  fall_seen = ~pin & last;
   // the first sample after reset only loads the history, so a pin that
   // idles high cannot fake an edge
   wire  next_edge = primed & (rising ? rise_seen : fall_seen);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last       <= 1'b0;
         primed     <= 1'b0;
         edge_pulse <= 1'b0;
      end else if (ce) begin
         last       <= pin;
         primed     <= 1'b1;
         edge_pulse <= next_edge;
      end
   end
endmodule // icl_edge_det

// [verification/icl_checker.sv]
// checker: timing relations on the interrupt control ports
module icl_checker
   import icl_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rstn,
   // watched ports
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        irq_ack,
   input wire logic        return_from_irq_instr,
   input wire logic [12:0] return_pc,
   input wire logic        irq_request,
   input wire logic        stack_push,
   input wire logic [12:0] stack_push_data,
   input wire logic        stack_pop,
   input wire logic        pc_load,
   input wire logic [12:0] pc_load_value,
   input wire logic        wake,
   input wire logic        asleep
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_ack_push_load: assert property (irq_ack |=> stack_push && pc_load)
      else $error("no push or load after acknowledge");
   a_fixed_vector: assert property (pc_load |-> pc_load_value == IRQ_VECTOR)
      else $error("vector value wrong");
   a_push_ret_pc: assert property (irq_ack |=> stack_push_data == $past(return_pc))
      else $error("pushed address wrong");
   a_push_cause: assert property (stack_push |-> $past(irq_ack))
      else $error("push without acknowledge");
   a_pop_on_ret: assert property (return_from_irq_instr |=> stack_pop)
      else $error("no pop after return");
   a_req_drops: assert property (irq_ack |-> ##2 !irq_request)
      else $error("request stays after acknowledge");
   a_reset_quiet: assert property ($rose(rstn) |-> !irq_request && !pc_load)
      else $error("request right after reset");
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   a_wake_leaves: assert property (
      wake |-> $past(asleep) && !asleep)
      else $error("wake without leaving sleep");
endmodule // icl_checker
bind icl_ctrl icl_checker i_chk (.clk, .rstn, .reg_rd, .reg_rdata, .irq_ack,
   .return_from_irq_instr, .return_pc, .irq_request, .stack_push,
   .stack_push_data, .stack_pop, .pc_load, .pc_load_value, .wake, .asleep);

// [verification/icl_core_model.sv]
// core sequencer model: acknowledges requests, issues returns
module icl_core_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // request side and bench control
   input  wire logic        irq_request,
   input  wire logic        slow,
   input  wire logic        ret_go,
   // sequencer outputs
   output logic             irq_ack,
   output logic             return_from_irq_instr,
   output logic      [12:0] return_pc
);
   logic [2:0] wait_cnt;
   logic       taken;
   // one acknowledge per request; the request lags the cleared enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {irq_ack, return_from_irq_instr, taken, wait_cnt} <= '0;
         return_pc <= '0;
      end else begin
         irq_ack <= 1'b0;
         return_from_irq_instr <= ret_go;
         return_pc <= return_pc + 13'h1;
         if (!irq_request) begin
            taken <= 1'b0;
            wait_cnt <= '0;
         end else if (!taken && wait_cnt >= (slow ? 3'h5 : 3'h0)) begin
            irq_ack <= 1'b1;
            taken <= 1'b1;
         end else if (!taken) begin
            wait_cnt <= wait_cnt + 3'h1;
         end
      end
   end
endmodule // icl_core_model

// [verification/tb.sv]
// testbench: register reads, flags, vectoring and sleep wake
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import icl_pkg::*;
   logic        clk = 0, rstn = 0, q1 = 0, q4 = 0, reg_wr = 0, reg_rd = 0;
   logic        ext_irq_pin = 0, timer_zero_overflow = 0, sleep_instr = 0;
   logic        slow = 0, ret_go = 0, rd_d = 0, ce = 1;
   logic [2:0]  reg_addr = '0;
   logic [7:0]  reg_wdata = '0, periph_set_a = '0, reg_rdata, r, exp_q[$];
   logic [3:0]  upper_io_port = '0;
   logic [0:0]  periph_set_b = '0;
   logic [1:0]  ph = '0;
   logic [31:0] seed = 32'h35;
   logic        irq_ack, return_from_irq_instr, irq_request, stack_push;
   logic        stack_pop, pc_load, wake, asleep;
   logic [12:0] return_pc, stack_push_data, pc_load_value;
   int          n_fail = 0, checks = 0;
   wire  [3:0]  mon = {pc_load, wake, asleep, irq_request};
   icl_ctrl i_dut (.clk, .rstn, .ce, .q1, .q4, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .ext_irq_pin, .timer_zero_overflow,
      .upper_io_port, .periph_set_a, .periph_set_b, .irq_ack,
      .return_from_irq_instr, .sleep_instr, .return_pc, .irq_request,
      .stack_push, .stack_push_data, .stack_pop, .pc_load, .pc_load_value,
      .wake, .asleep);
   icl_core_model i_core (.clk, .rstn, .irq_request, .slow, .ret_go, .irq_ack,
      .return_from_irq_instr, .return_pc);
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) begin
      ph <= ph + 2'h1;
      q1 <= ph == 2'h3;
      q4 <= ph == 2'h2;
   end
   // read data stands one cycle after the strobe only
   always @(posedge clk) begin
      if (rd_d) cmp8(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
   end
   function logic [31:0] xs(input logic [31:0] v);
      logic [31:0] t;
      t = v ^ (v << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task cmp8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: read %h, expected %h", $time, g, e);
      end
   endtask
   task cmp1(input logic g, input logic e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: flag %b, expected %b", $time, g, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      tick(1);
      reg_wr <= 1'b0;
      tick(1);
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      tick(1);
      reg_rd <= 1'b0;
      tick(1);
   endtask
   // 0 timer, 1 peripheral bit 0, 2 return, 3 sleep
   task kick(input int s);
      {sleep_instr, ret_go, periph_set_a[0], timer_zero_overflow} <= 4'h1 << s;
      tick(1);
      {sleep_instr, ret_go, periph_set_a[0], timer_zero_overflow} <= 4'h0;
   endtask
   task waitsig(input int s);
      int i;
      for (i = 0; i < 200 && mon[s] !== 1'b1; i++) tick(1);
      if (mon[s] !== 1'b1) begin
         n_fail++;
         $display("wrong value at %0t: wait ran out", $time);
         conclude();
      end
   endtask
   task note(input string s);
      $display("test %s done", s);
   endtask
   task conclude;
      $display("checks %0d, mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      tick(5);
      rstn <= 1'b1;
      tick(1);
      rd(ADDR_MAIN, MAIN_RESET);
      rd(ADDR_OPTION, OPTION_RESET);
      for (int a = 1; a < 5; a++) rd(3'(a), PREG_RESET);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
      note("reset");
      kick(0);
      tick(8);
      rd(ADDR_MAIN, 8'h04);
      upper_io_port <= 4'h5;
      tick(8);
      rd(ADDR_MAIN, 8'h05);
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_OPTION, p ? 8'hff : 8'hbf);
         ext_irq_pin <= 1'(p);
         tick(8);
         wr(ADDR_MAIN, 8'h00);
         ext_irq_pin <= !p;
         tick(8);
         rd(ADDR_MAIN, 8'h00);
         ext_irq_pin <= 1'(p);
         tick(8);
         rd(ADDR_MAIN, 8'h02);
      end
      note("flags");
      ce <= 1'b0;
      kick(0);
      ce <= 1'b1;
      rd(ADDR_MAIN, 8'h02);
      seed = xs(seed);
      r = seed[7:0];
      periph_set_a <= r;
      periph_set_b <= 1'b1;
      tick(1);
      periph_set_a <= '0;
      periph_set_b <= '0;
      tick(2);
      rd(ADDR_PFLAG_A, r);
      rd(ADDR_PFLAG_B, 8'h01);
      wr(ADDR_PEN_A, ~r);
      rd(ADDR_PEN_A, ~r);
      wr(ADDR_PFLAG_A, 8'h00);
      wr(ADDR_PFLAG_B, 8'h00);
      wr(ADDR_PEN_A, 8'h01);
      note("periph");
      for (int k = 0; k < 2; k++) begin
         slow <= k == 0;
         wr(ADDR_MAIN, k ? 8'hc0 : 8'ha0);
         kick(k);
         waitsig(3);
         tick(2);
         rd(ADDR_MAIN, k ? 8'h40 : 8'h24);
         wr(k ? ADDR_PFLAG_A : ADDR_MAIN, k ? 8'h00 : 8'h20);
         kick(2);
         tick(3);
         rd(ADDR_MAIN, k ? 8'hc0 : 8'ha0);
         tick(16);
         cmp1(irq_request, 1'b0);
      end
      wr(ADDR_MAIN, 8'ha0);
      kick(0);
      waitsig(0);
      wr(ADDR_MAIN, 8'h20);
      waitsig(3);
      kick(2);
      tick(3);
      rd(ADDR_MAIN, 8'h20);
      note("vector");
      wr(ADDR_MAIN, 8'h20);
      kick(3);
      waitsig(1);
      kick(0);
      waitsig(2);
      tick(16);
      cmp1(irq_request, 1'b0);
      note("sleep");
      conclude();
   end
endmodule // tb
